// file: verilog/ssm_cmd_top.sv
// Reset/standby and augmentation mask command interpreter, top level
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "ssm_defs.svh"
module ssm_cmd_top #(
	parameter int CYC_PER_SEC = `SSM_CYC_PER_SEC
) (
	input  wire logic                       sys_clk,
	input  wire logic                       rst_n,
	input  wire logic [7:0]                 rx_data,
	input  wire logic                       rx_valid,
	input  wire logic                       port_a_rx,
	input  wire logic                       port_b_rx,
	input  wire logic [4:0]                 avs_address,
	input  wire logic                       avs_read,
	input  wire logic                       avs_write,
	input  wire logic [31:0]                avs_writedata,
	output var  logic [31:0]                avs_readdata,
	output var  logic                       avs_waitrequest,
	output var  logic                       standby,
	output var  logic                       wake_pulse,
	output var  logic                       restart_req,
	output var  ssm_pkg::ssm_start_type     restart_kind,
	output var  logic [`SSM_OP_W-1:0]       nv_op,
	output var  logic [`SSM_MASK_W-1:0]     prn_disable
);
	import ssm_pkg::*;

	// Prescaler compares against CYC_PER_SEC - 1, so zero cannot work
	if (CYC_PER_SEC < 1) begin : g_bad_rate
		$error("CYC_PER_SEC must be at least 1");
	end

	function automatic logic [31:0] mask_of(input logic [7:0] b3, input logic [7:0] b2,
		input logic [7:0] b1, input logic [7:0] b0);
		mask_of = {b3, b2, b1, b0};
	endfunction

	// Reset release and pin synchronisers
	logic rst_s1_r, rst_sync_n;
	logic a_s1_r, a_s2_r, a_s3_r, b_s1_r, b_s2_r, b_s3_r;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rst_s1_r   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_s1_r   <= 1'b1;
			rst_sync_n <= rst_s1_r;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			{a_s1_r, a_s2_r, a_s3_r} <= 3'h7;
			{b_s1_r, b_s2_r, b_s3_r} <= 3'h7;
		end else begin
			{a_s1_r, a_s2_r, a_s3_r} <= {port_a_rx, a_s1_r, a_s2_r};
			{b_s1_r, b_s2_r, b_s3_r} <= {port_b_rx, b_s1_r, b_s2_r};
		end
	end

	// Start bit (falling edge) on an idle-high line counts as activity
	wire act_a = a_s3_r & ~a_s2_r;
	wire act_b = b_s3_r & ~b_s2_r;

	// Deframer
	logic       pkt_start, dat_valid, pkt_end;
	logic [7:0] pkt_id, dat_byte;

	ssm_frame_rx u_frame (
		.sys_clk    (sys_clk),
		.rst_sync_n (rst_sync_n),
		.rx_data    (rx_data),
		.rx_valid   (rx_valid),
		.pkt_start  (pkt_start),
		.pkt_id     (pkt_id),
		.dat_valid  (dat_valid),
		.dat_byte   (dat_byte),
		.pkt_end    (pkt_end)
	);

	// Payload store
	logic [7:0] pay_r [0:`SSM_PAY_DEPTH-1];
	logic [3:0] idx_r;

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			idx_r <= 4'h0;
			for (int i = 0; i < `SSM_PAY_DEPTH; i++) pay_r[i] <= 8'h00;
		end else if (pkt_start) begin
			idx_r <= 4'h0;
		end else if (dat_valid && idx_r != `SSM_LEN_OVF) begin
			if (idx_r < `SSM_LEN_FULL) pay_r[idx_r[2:0]] <= dat_byte;
			idx_r <= idx_r + 4'h1;
		end
	end

	// Reset/standby command decode
	wire [7:0] act_code = pay_r[`SSM_PAY_ACT];
	wire [7:0] nv_code  = pay_r[`SSM_PAY_NV];
	wire       c0_len   = (idx_r == `SSM_LEN_SHORT) || (idx_r == `SSM_LEN_FULL);
	wire       act_ok   = (act_code == `SSM_ACT_HOT) || (act_code == `SSM_ACT_WARM) ||
		(act_code == `SSM_ACT_COLD) || (act_code == `SSM_ACT_STANDBY) ||
		(act_code == `SSM_ACT_FACTORY);
	wire       c0_take  = pkt_end && pkt_id == `SSM_ID_RESET && c0_len && act_ok;
	wire [31:0] dur_all = mask_of(pay_r[`SSM_PAY_DUR], pay_r[`SSM_PAY_DUR+1],
		pay_r[`SSM_PAY_DUR+2], pay_r[`SSM_PAY_DUR+3]);
	// Short form carries no duration; top bit lies outside the legal range
	wire [`SSM_DUR_W-1:0] dur_in = (idx_r == `SSM_LEN_FULL) ? dur_all[`SSM_DUR_W-1:0] : '0;
	wire [`SSM_WK_W-1:0]  wake_req = pay_r[`SSM_PAY_WAKE][`SSM_WK_W-1:0];
	// Zero stay with the alarm bit is a host fault; the alarm is then not armed
	wire alarm_ok = wake_req[`SSM_WK_ALARM] && dur_in != '0;
	wire [`SSM_WK_W-1:0] wake_arm = {alarm_ok, wake_req[`SSM_WK_PORT_B:0]};

	logic [`SSM_OP_W-1:0] nv_nxt;
	always_comb begin
		nv_nxt = '0;
		case (nv_code)
			`SSM_NV_STORE_A, `SSM_NV_STORE_B: nv_nxt[`SSM_OP_STORE_CFG] = 1'b1;
			`SSM_NV_ERASE_NAV: nv_nxt[`SSM_OP_ERASE_NAVF] = 1'b1;
			`SSM_NV_ERASE_CFG: nv_nxt[`SSM_OP_ERASE_CFG] = 1'b1;
			`SSM_NV_ERASE_ALL: begin
				nv_nxt[`SSM_OP_ERASE_NAVF] = 1'b1;
				nv_nxt[`SSM_OP_ERASE_CFG]  = 1'b1;
				nv_nxt[`SSM_OP_ERASE_NAVB] = 1'b1;
			end
			default: nv_nxt = '0;
		endcase
	end

	ssm_start_type kind_nxt;
	always_comb begin
		case (act_code)
			`SSM_ACT_WARM:    kind_nxt = SSM_WARM;
			`SSM_ACT_COLD:    kind_nxt = SSM_COLD;
			`SSM_ACT_FACTORY: kind_nxt = SSM_FACTORY;
			default:          kind_nxt = SSM_HOT;
		endcase
	end

	// Mask command: byte 3 arrives first
	wire        c2_take  = pkt_end && pkt_id == `SSM_ID_MASK && idx_r == `SSM_LEN_MASK;
	wire [31:0] mask_in  = mask_of(pay_r[0], pay_r[1], pay_r[2], pay_r[3]);

	// Standby and alarm
	logic [`SSM_WK_W-1:0]  wake_cfg_r, wake_cause_r, fl_wake_r;
	logic [`SSM_DUR_W-1:0] dur_r, remain_r, fl_dur_r;
	logic [31:0]           pre_r;
	logic                  save_req;

	wire sec_tick  = standby && pre_r == 32'(CYC_PER_SEC - 1);
	wire alarm_hit = sec_tick && remain_r == `SSM_DUR_W'(1);
	wire [`SSM_WK_W-1:0] wake_hits = wake_cfg_r & {alarm_hit, act_b, act_a};
	wire wake_now  = standby && wake_hits != '0;
	wire enter_sb  = c0_take && act_code == `SSM_ACT_STANDBY;

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			standby      <= 1'b0;
			wake_pulse   <= 1'b0;
			wake_cause_r <= '0;
			pre_r        <= 32'h0;
			remain_r     <= '0;
		end else begin
			wake_pulse <= wake_now;
			if (enter_sb) begin
				standby      <= 1'b1;
				wake_cause_r <= '0;
				pre_r        <= 32'h0;
				remain_r     <= dur_in;
			end else if (wake_now) begin
				standby      <= 1'b0;
				wake_cause_r <= wake_hits;
			end else if (standby) begin
				pre_r <= sec_tick ? 32'h0 : pre_r + 32'h1;
				if (sec_tick && remain_r != '0) remain_r <= remain_r - `SSM_DUR_W'(1);
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			restart_req  <= 1'b0;
			restart_kind <= SSM_HOT;
			nv_op        <= '0;
			wake_cfg_r   <= '0;
			dur_r        <= '0;
			prn_disable  <= '0;
		end else begin
			restart_req <= c0_take && act_code != `SSM_ACT_STANDBY;
			nv_op       <= c0_take ? nv_nxt : '0;
			if (c0_take && act_code != `SSM_ACT_STANDBY) restart_kind <= kind_nxt;
			if (c0_take) begin
				wake_cfg_r <= wake_arm;
				dur_r      <= dur_in;
			end
			// Upper 13 mask bits are reserved and dropped
			if (c2_take) prn_disable <= mask_in[`SSM_MASK_W-1:0];
		end
	end

	// Flash copy of the wake settings follows only the save request
	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			fl_wake_r <= '0;
			fl_dur_r  <= '0;
		end else if (save_req) begin
			fl_wake_r <= wake_cfg_r;
			fl_dur_r  <= dur_r;
		end
	end

	// Avalon-MM slave: writes take no wait, reads one wait state
	logic rd_ack_r;
	logic [31:0] rd_nxt;
	wire [2:0] reg_idx = avs_address[4:2];
	assign save_req        = avs_write && reg_idx == `SSM_REG_CTRL &&
		avs_writedata[`SSM_CTRL_SAVE];
	assign avs_waitrequest = avs_read && !rd_ack_r;

	always_comb begin
		rd_nxt = 32'h0;
		case (reg_idx)
			`SSM_REG_STATUS: begin
				rd_nxt[`SSM_ST_STANDBY] = standby;
				rd_nxt[`SSM_ST_CAUSE +: `SSM_WK_W] = wake_cause_r;
				rd_nxt[`SSM_ST_KIND +: 2] = restart_kind;
			end
			`SSM_REG_WAKE:    rd_nxt[`SSM_WK_W-1:0] = wake_cfg_r;
			`SSM_REG_DUR:     rd_nxt[`SSM_DUR_W-1:0] = dur_r;
			`SSM_REG_MASK:    rd_nxt[`SSM_MASK_W-1:0] = prn_disable;
			`SSM_REG_FL_WAKE: rd_nxt[`SSM_WK_W-1:0] = fl_wake_r;
			`SSM_REG_FL_DUR:  rd_nxt[`SSM_DUR_W-1:0] = fl_dur_r;
			default:          rd_nxt = 32'h0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			rd_ack_r     <= 1'b0;
			avs_readdata <= 32'h0;
		end else begin
			rd_ack_r <= avs_read && !rd_ack_r;
			if (avs_read && !rd_ack_r) avs_readdata <= rd_nxt;
		end
	end

	// Checks
	property p_mask_load;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		c2_take |=> prn_disable == $past(mask_in[`SSM_MASK_W-1:0]);
	endproperty
	a_mask_load: assert property (p_mask_load) else $error("mask not loaded");

	property p_mask_prn135;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		c2_take && pay_r[2][7] && pay_r[1][2] |=> prn_disable[`SSM_BIT_PRN135] &&
			prn_disable[`SSM_BIT_PRN138];
	endproperty
	a_mask_prn135: assert property (p_mask_prn135) else $error("PRN bit map wrong");

	property p_mask_bad_len;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		pkt_end && pkt_id == `SSM_ID_MASK && idx_r != `SSM_LEN_MASK |=> $stable(prn_disable);
	endproperty
	a_mask_bad_len: assert property (p_mask_bad_len) else $error("mask changed");

	property p_nv_reserved;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		c0_take && nv_code < `SSM_NV_STORE_A |=> nv_op == '0;
	endproperty
	a_nv_reserved: assert property (p_nv_reserved) else $error("reserved nv acted");

	property p_nv_store;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		c0_take && (nv_code == `SSM_NV_STORE_A || nv_code == `SSM_NV_STORE_B)
			|=> nv_op == `SSM_OP_W'(1) ##1 nv_op == '0;
	endproperty
	a_nv_store: assert property (p_nv_store) else $error("store pulse wrong");

	property p_nv_erase_all;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		c0_take && nv_code == `SSM_NV_ERASE_ALL |=> nv_op == `SSM_OP_W'(4'hE);
	endproperty
	a_nv_erase_all: assert property (p_nv_erase_all) else $error("erase all wrong");

	property p_enter_standby;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		enter_sb |=> standby && !restart_req;
	endproperty
	a_enter_standby: assert property (p_enter_standby) else $error("no standby");

	property p_wake_a;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		standby && !enter_sb && wake_cfg_r[`SSM_WK_PORT_A] && act_a |=> !standby && wake_pulse;
	endproperty
	a_wake_a: assert property (p_wake_a) else $error("port A wake missed");

	property p_wake_b;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		standby && !enter_sb && wake_cfg_r[`SSM_WK_PORT_B] && act_b |=> !standby;
	endproperty
	a_wake_b: assert property (p_wake_b) else $error("port B wake missed");

	property p_no_wake_unarmed;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		standby && !enter_sb && wake_hits == '0 |=> standby;
	endproperty
	a_no_wake_unarmed: assert property (p_no_wake_unarmed) else $error("early wake");

	property p_flash_save_only;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		!save_req |=> $stable(fl_wake_r) && $stable(fl_dur_r);
	endproperty
	a_flash_save_only: assert property (p_flash_save_only) else $error("flash copy moved");

	property p_dle_collapse;
		@(posedge sys_clk) disable iff (!rst_sync_n)
		dat_valid && dat_byte == `SSM_DLE |-> $past(rx_valid && rx_data == `SSM_DLE, 1);
	endproperty
	a_dle_collapse: assert property (p_dle_collapse) else $error("stray DLE data");

	c_standby: cover property (@(posedge sys_clk) disable iff (!rst_sync_n) enter_sb);
	c_wake:    cover property (@(posedge sys_clk) disable iff (!rst_sync_n) wake_now);
	c_mask:    cover property (@(posedge sys_clk) disable iff (!rst_sync_n) c2_take);
	c_alarm:   cover property (@(posedge sys_clk) disable iff (!rst_sync_n) alarm_hit);
endmodule // ssm_cmd_top
`default_nettype wire

// file: verilog/ssm_defs.svh
// Constants for the standby/reset and augmentation mask command interpreter
`ifndef SSM_DEFS_SVH
`define SSM_DEFS_SVH

// Link framing bytes
`define SSM_DLE           8'h10
`define SSM_ETX           8'h03
// Packet identifiers
`define SSM_ID_RESET      8'hC0
`define SSM_ID_MASK       8'hC2
// Action codes, ASCII
`define SSM_ACT_HOT       8'h48
`define SSM_ACT_WARM      8'h57
`define SSM_ACT_COLD      8'h43
`define SSM_ACT_STANDBY   8'h53
`define SSM_ACT_FACTORY   8'h46
// Nonvolatile action codes
`define SSM_NV_STORE_A    8'h02
`define SSM_NV_STORE_B    8'h03
`define SSM_NV_ERASE_NAV  8'h04
`define SSM_NV_ERASE_CFG  8'h05
`define SSM_NV_ERASE_ALL  8'h06
// Nonvolatile operation pulse bits
`define SSM_OP_STORE_CFG  0
`define SSM_OP_ERASE_NAVF 1
`define SSM_OP_ERASE_CFG  2
`define SSM_OP_ERASE_NAVB 3
`define SSM_OP_W          4
// Wake condition bits
`define SSM_WK_PORT_A     0
`define SSM_WK_PORT_B     1
`define SSM_WK_ALARM      2
`define SSM_WK_W          3
// Payload lengths and indices
`define SSM_LEN_SHORT     4'h3
`define SSM_LEN_FULL      4'h7
`define SSM_LEN_MASK      4'h4
`define SSM_LEN_OVF       4'h8
`define SSM_PAY_DEPTH     7
`define SSM_PAY_ACT       0
`define SSM_PAY_NV        1
`define SSM_PAY_WAKE      2
`define SSM_PAY_DUR       3
// Mask layout: bit 0 is PRN 120
`define SSM_MASK_W        19
`define SSM_PRN_BASE      120
`define SSM_BIT_PRN135    15
`define SSM_BIT_PRN138    18
`define SSM_DUR_W         31
// Timing
`define SSM_CLK_NS        8
`define SSM_SEC_NS        1000000000
`define SSM_CYC_PER_SEC   (`SSM_SEC_NS / `SSM_CLK_NS)
// Register word indices (byte address bits 4:2)
`define SSM_REG_CTRL      3'h0
`define SSM_REG_STATUS    3'h1
`define SSM_REG_WAKE      3'h2
`define SSM_REG_DUR       3'h3
`define SSM_REG_MASK      3'h4
`define SSM_REG_FL_WAKE   3'h5
`define SSM_REG_FL_DUR    3'h6
`define SSM_CTRL_SAVE     0
`define SSM_ST_STANDBY    0
`define SSM_ST_CAUSE      1
`define SSM_ST_KIND       4

`endif

// file: verilog/ssm_pkg.sv
// Types shared by the command interpreter files
`default_nettype none
package ssm_pkg;
	typedef enum logic [1:0] {SSM_HOT, SSM_WARM, SSM_COLD, SSM_FACTORY} ssm_start_type;
	typedef enum logic [1:0] {SSM_HUNT, SSM_GET_ID, SSM_BODY, SSM_BODY_DLE} ssm_rx_state_type;
endpackage
`default_nettype wire

// file: verilog/ssm_frame_rx.sv
// Packet deframer: DLE id payload DLE ETX, with DLE stuffing removed
`timescale 1ns/1ps
`default_nettype none
`include "ssm_defs.svh"
module ssm_frame_rx (
	input  wire logic       sys_clk,
	input  wire logic       rst_sync_n,
	input  wire logic [7:0] rx_data,
	input  wire logic       rx_valid,
	output var  logic       pkt_start,
	output var  logic [7:0] pkt_id,
	output var  logic       dat_valid,
	output var  logic [7:0] dat_byte,
	output var  logic       pkt_end
);
	import ssm_pkg::*;

	ssm_rx_state_type state_r;
	ssm_rx_state_type state_nxt;
	logic             start_nxt;
	logic             dat_nxt;
	logic             end_nxt;

	wire is_dle = (rx_data == `SSM_DLE);
	wire is_etx = (rx_data == `SSM_ETX);

	always_comb begin
		state_nxt = state_r;
		start_nxt = 1'b0;
		dat_nxt   = 1'b0;
		end_nxt   = 1'b0;
		if (rx_valid) begin
			case (state_r)
				SSM_HUNT: if (is_dle) state_nxt = SSM_GET_ID;
				SSM_GET_ID: begin
					// An id of DLE or ETX cannot open a packet
					if (is_dle || is_etx) begin
						state_nxt = SSM_HUNT;
					end else begin
						start_nxt = 1'b1;
						state_nxt = SSM_BODY;
					end
				end
				SSM_BODY: begin
					if (is_dle) state_nxt = SSM_BODY_DLE;
					else dat_nxt = 1'b1;
				end
				SSM_BODY_DLE: begin
					if (is_dle) begin
						dat_nxt   = 1'b1;
						state_nxt = SSM_BODY;
					end else if (is_etx) begin
						end_nxt   = 1'b1;
						state_nxt = SSM_HUNT;
					end else begin
						// Lone DLE: drop packet, resync on this byte as a new id
						start_nxt = 1'b1;
						state_nxt = SSM_BODY;
					end
				end
				default: state_nxt = SSM_HUNT;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_r   <= SSM_HUNT;
			pkt_start <= 1'b0;
			pkt_id    <= 8'h00;
			dat_valid <= 1'b0;
			dat_byte  <= 8'h00;
			pkt_end   <= 1'b0;
		end else begin
			state_r   <= state_nxt;
			pkt_start <= start_nxt;
			dat_valid <= dat_nxt;
			pkt_end   <= end_nxt;
			if (start_nxt) pkt_id <= rx_data;
			if (dat_nxt) dat_byte <= rx_data;
		end
	end
endmodule // ssm_frame_rx
`default_nettype wire

// file: tb/ssm_host_model.sv
// Host-side link model: sends framed command packets one byte per cycle
`timescale 1ns/1ps
`default_nettype none
`include "ssm_defs.svh"
module ssm_host_model (
	input  wire logic       sys_clk,
	output var  logic [7:0] rx_data,
	output var  logic       rx_valid
);
	initial begin
		rx_data = 8'hA5;
		rx_valid = 1'b0;
	end

	task automatic put(input logic [7:0] b);
		@(posedge sys_clk);
		rx_data <= b;
		rx_valid <= 1'b1;
	endtask

	// Payload goes out in array order; mask callers list byte 3 first
	task automatic send_pkt(input logic [7:0] id, input logic [7:0] pl [8], input int n);
		put(`SSM_DLE);
		put(id);
		for (int i = 0; i < n; i++) begin
			put(pl[i]);
			if (pl[i] == `SSM_DLE)
				put(`SSM_DLE);
		end
		put(`SSM_DLE);
		put(`SSM_ETX);
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		// Idle line must not keep showing the last byte
		rx_data <= ~rx_data;
	endtask
endmodule // ssm_host_model
`default_nettype wire

// file: tb/test_shutdown_standby_sbas_mask_cmds.sv
// Self-checking bench for the standby/reset and augmentation mask interpreter
`timescale 1ns/1ps
`default_nettype none
`include "ssm_defs.svh"
`define CHK(g, e) chk(32'(g), 32'(e))
module test_shutdown_standby_sbas_mask_cmds;
	import ssm_pkg::*;
	logic                   sys_clk = 1'b0;
	logic                   rst_n = 1'b0;
	logic [7:0]             rx_data;
	logic                   rx_valid;
	logic                   port_a_rx = 1'b1;
	logic                   port_b_rx = 1'b1;
	logic [4:0]             avs_address = 5'h00;
	logic                   avs_read = 1'b0;
	logic                   avs_write = 1'b0;
	logic [31:0]            avs_writedata = 32'h0;
	logic [31:0]            avs_readdata;
	logic                   avs_waitrequest;
	logic                   standby;
	logic                   wake_pulse;
	logic                   restart_req;
	ssm_start_type          restart_kind;
	logic [3:0]             nv_op;
	logic [18:0]            prn_disable;
	logic [27:0]            exp_q [$];
	logic [1:0]             e_kind = 2'h0;
	logic [18:0]            e_mask = 19'h0;
	logic                   sb_q = 1'b0;
	logic [18:0]            mask_q = 19'h0;
	logic [31:0]            tmp;
	logic [31:0]            m;
	int                     miscompares = 0;
	int                     n_checks = 0;
	logic [7:0]             acts [4] = '{`SSM_ACT_HOT, `SSM_ACT_WARM, `SSM_ACT_COLD,
		`SSM_ACT_FACTORY};
	logic [3:0]             nvx [7] = '{4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h4, 4'hE};
	logic [31:0]            mtab [4] = '{32'h00008000, 32'h00040000, 32'h00000010,
		32'hFFFFFFFF};

	always #4 sys_clk = ~sys_clk;

	ssm_host_model host (.sys_clk(sys_clk), .rx_data(rx_data), .rx_valid(rx_valid));

	ssm_cmd_top #(.CYC_PER_SEC(10)) dut (
		.sys_clk(sys_clk), .rst_n(rst_n), .rx_data(rx_data), .rx_valid(rx_valid),
		.port_a_rx(port_a_rx), .port_b_rx(port_b_rx), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.standby(standby), .wake_pulse(wake_pulse), .restart_req(restart_req),
		.restart_kind(restart_kind), .nv_op(nv_op), .prn_disable(prn_disable));

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask

	task end_sim;
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	function automatic logic [27:0] ew(logic sb, logic rq, logic [3:0] nv, logic wk);
		return {sb, rq, e_kind, nv, wk, e_mask};
	endfunction

	// Every output event is matched against the oldest expected note
	always @(posedge sys_clk) begin
		if (rst_n) begin
			if (restart_req || nv_op != 4'h0 || wake_pulse || (standby && !sb_q)
				|| prn_disable != mask_q) begin
				if (exp_q.size() == 0) begin
					miscompares++;
					$display("wrong value at %0t: unexpected output event", $time);
				end else
					`CHK({standby, restart_req, restart_kind, nv_op, wake_pulse, prn_disable},
						exp_q.pop_front());
			end
			sb_q <= standby;
			mask_q <= prn_disable;
		end
	end

	// Avalon master: hold the request until waitrequest is sampled low
	task automatic av(input logic rd, input logic [4:0] a, input logic [31:0] wd,
		output logic [31:0] rdv);
		avs_read <= rd;
		avs_write <= !rd;
		avs_address <= a;
		avs_writedata <= wd;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rdv = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e,
		input logic [31:0] k = 32'hFFFFFFFF);
		logic [31:0] v;
		av(1'b1, a, 32'h0, v);
		`CHK(v & k, e);
	endtask

	task automatic c0(input logic [7:0] act, input logic [7:0] nv, input logic [2:0] wk,
		input logic [31:0] d, input int n);
		logic [7:0] pl [8];
		pl = '{act, nv, {5'h0, wk}, d[31:24], d[23:16], d[15:8], d[7:0], 8'h00};
		host.send_pkt(`SSM_ID_RESET, pl, n);
	endtask

	task automatic mk(input logic [31:0] mv, input int n);
		logic [7:0] pl [8];
		pl = '{mv[31:24], mv[23:16], mv[15:8], mv[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
		host.send_pkt(`SSM_ID_MASK, pl, n);
	endtask

	task automatic wait_q;
		for (int i = 0; i < 200 && exp_q.size() != 0; i++)
			@(posedge sys_clk);
		if (exp_q.size() != 0) begin
			miscompares++;
			$display("wrong value at %0t: expected event missing", $time);
			exp_q.delete();
		end
	endtask

	// Activity is a falling edge; the pin returns to idle high
	task automatic pulse(input logic b);
		if (b)
			port_b_rx <= 1'b0;
		else
			port_a_rx <= 1'b0;
		repeat (4) @(posedge sys_clk);
		port_a_rx <= 1'b1;
		port_b_rx <= 1'b1;
		@(posedge sys_clk);
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		miscompares++;
		$display("wrong value at %0t: timeout", $time);
		end_sim;
	end

	initial begin
		void'($urandom(87889));
		repeat (6) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd_chk(5'h10, 32'h0);
		for (int i = 0; i < 7; i++) begin
			e_kind = 2'(i % 4);
			exp_q.push_back(ew(1'b0, 1'b1, nvx[i], 1'b0));
			c0(acts[i % 4], 8'(i), 3'h0, 32'h0, 3);
			wait_q;
		end
		// Bad action code and short mask are dropped whole
		c0(8'h58, 8'h02, 3'h0, 32'h0, 3);
		mk(32'h0000FFFF, 3);
		repeat (10) @(posedge sys_clk);
		for (int i = 0; i < 9; i++) begin
			m = (i < 4) ? mtab[i] : ((i < 8) ? $urandom() : 32'h0);
			if (m[18:0] != e_mask) begin
				e_mask = m[18:0];
				exp_q.push_back(ew(1'b0, 1'b0, 4'h0, 1'b0));
			end
			mk(m, 4);
			wait_q;
		end
		av(1'b0, 5'h10, 32'hFFFFFFFF, tmp);
		rd_chk(5'h10, 32'h0);
		rd_chk(5'h1C, 32'h0);
		exp_q.push_back(ew(1'b1, 1'b0, 4'h0, 1'b0));
		c0(`SSM_ACT_STANDBY, 8'h00, 3'b101, 32'h10, 7);
		wait_q;
		rd_chk(5'h14, 32'h0);
		rd_chk(5'h08, 32'h5);
		av(1'b0, 5'h00, 32'h1, tmp);
		rd_chk(5'h14, 32'h5);
		rd_chk(5'h18, 32'h10);
		exp_q.push_back(ew(1'b0, 1'b0, 4'h0, 1'b1));
		pulse(1'b0);
		wait_q;
		rd_chk(5'h04, 32'h2, 32'hF);
		exp_q.push_back(ew(1'b1, 1'b0, 4'h0, 1'b0));
		c0(`SSM_ACT_STANDBY, 8'h00, 3'b110, 32'h2, 7);
		wait_q;
		pulse(1'b0);
		repeat (4) @(posedge sys_clk);
		`CHK(standby, 1'b1);
		exp_q.push_back(ew(1'b0, 1'b0, 4'h0, 1'b1));
		pulse(1'b1);
		wait_q;
		rd_chk(5'h04, 32'h4, 32'hF);
		exp_q.push_back(ew(1'b1, 1'b0, 4'h0, 1'b0));
		c0(`SSM_ACT_STANDBY, 8'h00, 3'b100, 32'h2, 7);
		wait_q;
		repeat (12) @(posedge sys_clk);
		`CHK(standby, 1'b1);
		exp_q.push_back(ew(1'b0, 1'b0, 4'h0, 1'b1));
		wait_q;
		rd_chk(5'h04, 32'h8, 32'hF);
		end_sim;
	end
endmodule // test_shutdown_standby_sbas_mask_cmds
`default_nettype wire
